/* src/csr_params.svh */
// Constants of the core special-function register block.
// Assumes an 8-bit data path and a 16-bit program word.
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// Special register addresses in bank 0
`define CSR_ADDR_PORT_A  8'h00
`define CSR_ADDR_PTR_A   8'h01
`define CSR_ADDR_PORT_B  8'h02
`define CSR_ADDR_PTR_B   8'h03
`define CSR_ADDR_BANK    8'h04
`define CSR_ADDR_WORK    8'h05
`define CSR_ADDR_PCL     8'h06
`define CSR_ADDR_TBL_LO  8'h07
`define CSR_ADDR_TBL_UP  8'h08
`define CSR_ADDR_TBL_HI  8'h09
`define CSR_ADDR_FLAGS   8'h0A

// Bank codes and read values
`define CSR_BANK_RST     2'h0
`define CSR_BANK_RSVD    2'h3
`define CSR_UNUSED_RD    8'h00

// Flag register field positions
`define CSR_FLG_C        0
`define CSR_FLG_AC       1
`define CSR_FLG_Z        2
`define CSR_FLG_OV       3
`define CSR_FLG_SLEEP    4
`define CSR_FLG_WDT      5

`endif

/* src/csr_pkg.sv */
// Types shared by the core special-function register block.
// Assumes the CPU sequencer drives csr_op_e codes.
package csr_pkg;
    // Operations the working-register datapath performs
    typedef enum logic [3:0] {
        CSR_OP_PASS,
        CSR_OP_ADD,
        CSR_OP_ADC,
        CSR_OP_SUB,
        CSR_OP_SBC,
        CSR_OP_AND,
        CSR_OP_OR,
        CSR_OP_XOR,
        CSR_OP_RLC,
        CSR_OP_RRC
    } csr_op_e;
endpackage

/* src/csr_alu_if.sv */
// Operand and flag bundle between the core and its ALU.
// Assumes purely combinational use inside one clock domain.
interface csr_alu_if;
    import csr_pkg::*;
    csr_op_e    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [7:0] res;
    logic       c;
    logic       ac;
    logic       z;
    logic       ov;
    logic       upd_c;
    logic       upd_ac;
    logic       upd_z;
    logic       upd_ov;
    modport alu  (input op, a, b, cin, output res, c, ac, z, ov, upd_c, upd_ac, upd_z, upd_ov);
    modport core (output op, a, b, cin, input res, c, ac, z, ov, upd_c, upd_ac, upd_z, upd_ov);
endinterface

/* src/csr_alu.sv */
// Combinational ALU producing a result and the four arithmetic flags.
// Assumes the core registers both result and flags.
module csr_alu
    import csr_pkg::*;
(
    csr_alu_if.alu alu
);
    logic [7:0] bx;
    logic       ci;
    logic       sub_op;
    logic [4:0] lo;
    logic [7:0] s7;
    logic [8:0] sum;

    ////////////////////////////////////////////////////////////////////////
    // Subtract is add of the inverted operand, so carry means no borrow
    always_comb begin
        sub_op = (alu.op == CSR_OP_SUB) || (alu.op == CSR_OP_SBC);
        bx     = sub_op ? ~alu.b : alu.b;
        ci     = (alu.op == CSR_OP_ADD) ? 1'b0 : (alu.op == CSR_OP_SUB) ? 1'b1 : alu.cin;
        lo     = {1'b0, alu.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
        s7     = {1'b0, alu.a[6:0]} + {1'b0, bx[6:0]} + {7'h00, ci};
        sum    = {1'b0, alu.a} + {1'b0, bx} + {8'h00, ci};
        alu.res    = alu.b;
        alu.c      = 1'b0;
        alu.ac     = 1'b0;
        alu.ov     = 1'b0;
        alu.upd_c  = 1'b0;
        alu.upd_ac = 1'b0;
        alu.upd_z  = 1'b0;
        alu.upd_ov = 1'b0;
        unique case (alu.op)
            CSR_OP_ADD, CSR_OP_ADC, CSR_OP_SUB, CSR_OP_SBC: begin
                alu.res    = sum[7:0];
                alu.c      = sum[8];
                alu.ac     = lo[4];
                alu.ov     = s7[7] ^ sum[8];
                alu.upd_c  = 1'b1;
                alu.upd_ac = 1'b1;
                alu.upd_z  = 1'b1;
                alu.upd_ov = 1'b1;
            end
            CSR_OP_AND: begin
                alu.res   = alu.a & alu.b;
                alu.upd_z = 1'b1;
            end
            CSR_OP_OR: begin
                alu.res   = alu.a | alu.b;
                alu.upd_z = 1'b1;
            end
            CSR_OP_XOR: begin
                alu.res   = alu.a ^ alu.b;
                alu.upd_z = 1'b1;
            end
            CSR_OP_RLC: begin
                alu.res   = {alu.a[6:0], alu.cin};
                alu.c     = alu.a[7];
                alu.upd_c = 1'b1;
            end
            CSR_OP_RRC: begin
                alu.res   = {alu.cin, alu.a[7:1]};
                alu.c     = alu.a[0];
                alu.upd_c = 1'b1;
            end
            CSR_OP_PASS: begin
                alu.res = alu.b;
            end
        endcase
        alu.z = (alu.res == 8'h00);
    end
endmodule

/* src/csr_dmem.sv */
// General-purpose upper halves of the data-memory banks.
// Assumes the core filters reserved banks; read is combinational.
module csr_dmem #(
    parameter int DEPTH = 128,
    parameter int BANKS = 3
) (
    input  wire logic       i_clk,
    input  wire logic       i_wr,
    input  wire logic [1:0] i_bank,
    input  wire logic [6:0] i_idx,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [BANKS*DEPTH];
    int         slot;

    // Bank-major placement; banks at or above BANKS read as zero
    always_comb begin
        slot    = int'(i_bank) * DEPTH + int'(i_idx);
        o_rdata = (int'(i_bank) < BANKS) ? mem[slot] : 8'h00;
    end

    // Write port
    always_ff @(posedge i_clk) begin
        if (i_wr && (int'(i_bank) < BANKS)) begin
            mem[slot] <= i_wdata;
        end
    end
endmodule

/* src/csr_core.sv */
// Core special registers: indirect ports, bank select, flags, table read.
// Assumes a CPU sequencer issuing one-cycle requests on i_clk.
`include "csr_params.svh"

module csr_core
    import csr_pkg::*;
#(
    parameter int PC_W = 13
) (
    input  wire logic            i_clk,
    input  wire logic            i_rst_n,
    input  wire logic            i_soft_rst,
    input  wire logic            i_soft_rst_wdt_lp,
    input  wire logic            i_mem_rd,
    input  wire logic            i_mem_wr,
    input  wire logic [7:0]      i_mem_addr,
    output logic      [7:0]      o_mem_rdata,
    output logic                 o_mem_rvalid,
    input  wire logic            i_alu_go,
    input  wire csr_op_e         i_alu_op,
    input  wire logic [7:0]      i_alu_b,
    output logic      [7:0]      o_working_reg,
    output logic      [7:0]      o_flags,
    input  wire logic [PC_W-1:0] i_pc,
    output logic                 o_pc_load,
    output logic      [PC_W-1:0] o_pc_target,
    output logic                 o_dummy_cycle,
    input  wire logic            i_tbl_rd,
    output logic                 o_prog_rd,
    output logic      [15:0]     o_prog_addr,
    input  wire logic            i_prog_valid,
    input  wire logic [15:0]     i_prog_data,
    output logic      [7:0]      o_tbl_low,
    output logic                 o_tbl_low_valid,
    input  wire logic            i_wdt_timeout,
    input  wire logic            i_watchdog_kick_instr,
    input  wire logic            i_halt
);

    ////////////////////////////////////////////////////////////////////////
    // State record

    typedef struct packed {
        logic [7:0]      mem_pointer_a;
        logic [7:0]      mem_pointer_b;
        logic [1:0]      bank_select_bits;
        logic [7:0]      working_reg;
        logic [7:0]      table_pointer_low;
        logic [7:0]      table_pointer_high;
        logic [7:0]      table_read_upper;
        logic            carry_flag;
        logic            nibble_out_flag;
        logic            zero_flag;
        logic            twos_complement_wrap_flag;
        logic            sleep_entered_flag;
        logic            wdt_expired_flag;
        logic [7:0]      rdata;
        logic            rvalid;
        logic            pc_load;
        logic [PC_W-1:0] pc_target;
        logic            dummy;
        logic            prog_rd;
        logic [15:0]     prog_addr;
        logic [7:0]      tbl_low;
        logic            tbl_low_vld;
    } csr_core_s;

    csr_core_s  st_ff;
    csr_core_s  nxt_st;

    logic [1:0] eff_bank;
    logic [7:0] eff_idx;
    logic       eff_gp;
    logic       eff_sfr;
    logic [7:0] sfr_rd;
    logic [7:0] flag_view;
    logic [7:0] bank_view;
    logic [7:0] ram_rdata;
    logic       ram_wr;

    csr_alu_if alu_bus ();

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    csr_alu u_alu (
        .alu (alu_bus.alu)
    );

    csr_dmem #(
        .DEPTH (128),
        .BANKS (3)
    ) u_dmem (
        .i_clk   (i_clk),
        .i_wr    (ram_wr),
        .i_bank  (eff_bank),
        .i_idx   (eff_idx[6:0]),
        .i_wdata (st_ff.working_reg),
        .o_rdata (ram_rdata)
    );

    // ALU always works on the working register
    always_comb begin
        alu_bus.op  = i_alu_op;
        alu_bus.a   = st_ff.working_reg;
        alu_bus.b   = i_alu_b;
        alu_bus.cin = st_ff.carry_flag;
    end

    ////////////////////////////////////////////////////////////////////////
    // Address resolution

    // Port registers redirect through their pointers
    always_comb begin
        unique case (i_mem_addr)
            `CSR_ADDR_PORT_A: begin
                eff_bank = `CSR_BANK_RST;
                eff_idx  = st_ff.mem_pointer_a;
            end
            `CSR_ADDR_PORT_B: begin
                eff_bank = st_ff.bank_select_bits;
                eff_idx  = st_ff.mem_pointer_b;
            end
            default: begin
                eff_bank = `CSR_BANK_RST;
                eff_idx  = i_mem_addr;
            end
        endcase
        eff_gp  = eff_idx[7] && (eff_bank != `CSR_BANK_RSVD);
        eff_sfr = !eff_idx[7] && (eff_bank == `CSR_BANK_RST);
        ram_wr  = i_mem_wr && eff_gp;
    end

    // Register views
    always_comb begin
        flag_view                 = 8'h00;
        flag_view[`CSR_FLG_C]     = st_ff.carry_flag;
        flag_view[`CSR_FLG_AC]    = st_ff.nibble_out_flag;
        flag_view[`CSR_FLG_Z]     = st_ff.zero_flag;
        flag_view[`CSR_FLG_OV]    = st_ff.twos_complement_wrap_flag;
        flag_view[`CSR_FLG_SLEEP] = st_ff.sleep_entered_flag;
        flag_view[`CSR_FLG_WDT]   = st_ff.wdt_expired_flag;
        bank_view                 = {6'h00, st_ff.bank_select_bits};
    end

    // Special register read decode
    always_comb begin
        unique case (eff_idx)
            `CSR_ADDR_PTR_A:  sfr_rd = st_ff.mem_pointer_a;
            `CSR_ADDR_PTR_B:  sfr_rd = st_ff.mem_pointer_b;
            `CSR_ADDR_BANK:   sfr_rd = bank_view;
            `CSR_ADDR_WORK:   sfr_rd = st_ff.working_reg;
            `CSR_ADDR_PCL:    sfr_rd = i_pc[7:0];
            `CSR_ADDR_TBL_LO: sfr_rd = st_ff.table_pointer_low;
            `CSR_ADDR_TBL_UP: sfr_rd = st_ff.table_read_upper;
            `CSR_ADDR_TBL_HI: sfr_rd = st_ff.table_pointer_high;
            `CSR_ADDR_FLAGS:  sfr_rd = flag_view;
            default:          sfr_rd = `CSR_UNUSED_RD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_st             = st_ff;
        nxt_st.rvalid      = i_mem_rd;
        nxt_st.pc_load     = 1'b0;
        nxt_st.dummy       = st_ff.pc_load;
        nxt_st.prog_rd     = 1'b0;
        nxt_st.tbl_low_vld = 1'b0;

        // Read data: memory, special register or zero
        if (i_mem_rd) begin
            if (eff_gp) begin
                nxt_st.rdata = ram_rdata;
            end else if (eff_sfr) begin
                nxt_st.rdata = sfr_rd;
            end else begin
                nxt_st.rdata = `CSR_UNUSED_RD;
            end
        end

        // Special register writes, data always from working register
        if (i_mem_wr && eff_sfr) begin
            unique case (eff_idx)
                `CSR_ADDR_PTR_A:  nxt_st.mem_pointer_a = st_ff.working_reg;
                `CSR_ADDR_PTR_B:  nxt_st.mem_pointer_b = st_ff.working_reg;
                `CSR_ADDR_BANK:   nxt_st.bank_select_bits = st_ff.working_reg[1:0];
                `CSR_ADDR_TBL_LO: nxt_st.table_pointer_low = st_ff.working_reg;
                `CSR_ADDR_TBL_HI: nxt_st.table_pointer_high = st_ff.working_reg;
                `CSR_ADDR_PCL: begin
                    nxt_st.pc_load   = 1'b1;
                    nxt_st.pc_target = {i_pc[PC_W-1:8], st_ff.working_reg};
                end
                `CSR_ADDR_FLAGS: begin
                    nxt_st.carry_flag                = st_ff.working_reg[`CSR_FLG_C];
                    nxt_st.nibble_out_flag           = st_ff.working_reg[`CSR_FLG_AC];
                    nxt_st.zero_flag                 = st_ff.working_reg[`CSR_FLG_Z];
                    nxt_st.twos_complement_wrap_flag = st_ff.working_reg[`CSR_FLG_OV];
                end
                default: begin
                    nxt_st.rdata = nxt_st.rdata;
                end
            endcase
        end

        // ALU results land in the working register only
        if (i_alu_go) begin
            nxt_st.working_reg = alu_bus.res;
            if (alu_bus.upd_c) begin
                nxt_st.carry_flag = alu_bus.c;
            end
            if (alu_bus.upd_ac) begin
                nxt_st.nibble_out_flag = alu_bus.ac;
            end
            if (alu_bus.upd_z) begin
                nxt_st.zero_flag = alu_bus.z;
            end
            if (alu_bus.upd_ov) begin
                nxt_st.twos_complement_wrap_flag = alu_bus.ov;
            end
        end

        // Table read request and returned word
        if (i_tbl_rd) begin
            nxt_st.prog_rd   = 1'b1;
            nxt_st.prog_addr = {st_ff.table_pointer_high, st_ff.table_pointer_low};
        end
        if (i_prog_valid) begin
            nxt_st.table_read_upper = i_prog_data[15:8];
            nxt_st.tbl_low          = i_prog_data[7:0];
            nxt_st.tbl_low_vld      = 1'b1;
        end

        // System flags; status has no stack path on calls
        if (i_watchdog_kick_instr) begin
            nxt_st.sleep_entered_flag = 1'b0;
            nxt_st.wdt_expired_flag   = 1'b0;
        end
        if (i_halt) begin
            nxt_st.sleep_entered_flag = 1'b1;
            nxt_st.wdt_expired_flag   = 1'b0;
        end
        if (i_wdt_timeout) begin
            nxt_st.wdt_expired_flag = 1'b1;
        end

        // Non-power-up reset returns bank 0 unless low-power watchdog
        if (i_soft_rst && !i_soft_rst_wdt_lp) begin
            nxt_st.bank_select_bits = `CSR_BANK_RST;
        end
    end

    // State register; power-up clears everything
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_mem_rdata     = st_ff.rdata;
    assign o_mem_rvalid    = st_ff.rvalid;
    assign o_working_reg   = st_ff.working_reg;
    assign o_flags         = flag_view;
    assign o_pc_load       = st_ff.pc_load;
    assign o_pc_target     = st_ff.pc_target;
    assign o_dummy_cycle   = st_ff.dummy;
    assign o_prog_rd       = st_ff.prog_rd;
    assign o_prog_addr     = st_ff.prog_addr;
    assign o_tbl_low       = st_ff.tbl_low;
    assign o_tbl_low_valid = st_ff.tbl_low_vld;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    logic [8:0] chk_sum;
    assign chk_sum = {1'b0, st_ff.working_reg} + {1'b0, i_alu_b};

    chk_port_self_zero: assert property (
        i_mem_rd && i_mem_addr == `CSR_ADDR_PORT_A && st_ff.mem_pointer_a == `CSR_ADDR_PORT_A
        |=> o_mem_rvalid && o_mem_rdata == 8'h00)
        else $error("port register read through itself not zero");

    chk_port_redirect: assert property (
        i_mem_rd && i_mem_addr == `CSR_ADDR_PORT_A && st_ff.mem_pointer_a == `CSR_ADDR_PTR_B
        |=> o_mem_rdata == $past(st_ff.mem_pointer_b))
        else $error("indirect read did not reach pointed register");

    chk_bank_clear: assert property (
        i_soft_rst && !i_soft_rst_wdt_lp |=> st_ff.bank_select_bits == 2'h0)
        else $error("reset did not return bank 0");

    chk_bank_keep: assert property (
        i_soft_rst && i_soft_rst_wdt_lp && !i_mem_wr |=> $stable(st_ff.bank_select_bits))
        else $error("low-power watchdog reset changed bank");

    chk_bank_upper_zero: assert property (
        i_mem_rd && i_mem_addr == `CSR_ADDR_BANK |=> o_mem_rdata[7:2] == 6'h00)
        else $error("bank register upper bits not zero");

    chk_flag_write_sys: assert property (
        i_mem_wr && i_mem_addr == `CSR_ADDR_FLAGS && !i_wdt_timeout && !i_halt
        && !i_watchdog_kick_instr |=> $stable(o_flags[5:4]))
        else $error("flag write changed system flags");

    chk_pcl_jump: assert property (
        i_mem_wr && i_mem_addr == `CSR_ADDR_PCL
        |=> o_pc_load && o_pc_target[7:0] == $past(st_ff.working_reg) ##1 o_dummy_cycle && !o_pc_load)
        else $error("counter-low write jump or dummy cycle wrong");

    chk_table_addr: assert property (
        i_tbl_rd |=> o_prog_rd && o_prog_addr == $past({st_ff.table_pointer_high, st_ff.table_pointer_low}))
        else $error("table fetch address wrong");

    chk_wdt_set: assert property (
        i_wdt_timeout |=> o_flags[`CSR_FLG_WDT] ##1 (o_flags[`CSR_FLG_WDT] || $past(i_halt)
        || $past(i_watchdog_kick_instr)))
        else $error("watchdog flag not set by time-out");

    chk_sleep_set: assert property (
        i_halt |=> o_flags[`CSR_FLG_SLEEP])
        else $error("sleep flag not set by power-down");

    chk_add_carry: assert property (
        i_alu_go && i_alu_op == CSR_OP_ADD |=> o_flags[`CSR_FLG_C] == $past(chk_sum[8]))
        else $error("add carry wrong");

    chk_zero_and: assert property (
        i_alu_go && i_alu_op == CSR_OP_AND && (st_ff.working_reg & i_alu_b) == 8'h00
        |=> o_flags[`CSR_FLG_Z] && o_working_reg == 8'h00)
        else $error("zero flag not set on zero result");

    cov_bank2_write: cover property (
        i_mem_wr && i_mem_addr == `CSR_ADDR_PORT_B && st_ff.bank_select_bits == 2'h2);
    cov_pcl_jump: cover property (o_pc_load ##1 o_dummy_cycle);
    cov_table_done: cover property (o_prog_rd ##[1:4] o_tbl_low_valid);
    cov_bank_kept: cover property (
        i_soft_rst && i_soft_rst_wdt_lp && st_ff.bank_select_bits != 2'h0);

endmodule

/* tb/csr_prog_model.sv */
// Program-memory model answering table reads.
// Assumes one-cycle read pulses with the address held.
module csr_prog_model (
    input  wire logic        i_clk,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_slow,
    output logic             o_valid,
    output logic      [15:0] o_data
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////
    // Answer after one or five cycles; idle data lines invert
    initial begin
        o_valid = 1'b0;
        o_data  = 16'h0000;
        forever begin
            @(posedge i_clk);
            if (i_rd) begin
                repeat (i_slow ? 5 : 1) @(posedge i_clk);
                o_valid <= 1'b1;
                o_data  <= i_addr ^ 16'hA5C3;
                @(posedge i_clk);
                o_valid <= 1'b0;
                o_data  <= ~o_data;
            end
        end
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench of the core special registers.
// Assumes csr_core and the program model; inputs move on falling edges.
`include "csr_params.svh"
module testbench
    import csr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk, i_rst_n, i_soft_rst, i_soft_rst_wdt_lp, i_mem_rd, i_mem_wr, i_alu_go, i_tbl_rd;
    logic i_prog_valid, i_wdt_timeout, i_watchdog_kick_instr, i_halt, o_mem_rvalid, o_pc_load;
    logic o_dummy_cycle, o_prog_rd, o_tbl_low_valid, slow;
    logic dummy_due = 1'b0;
    logic [7:0] i_mem_addr, i_alu_b, o_mem_rdata, o_working_reg, o_flags, o_tbl_low, d, lo, hi;
    logic [7:0] dv [4];
    logic [12:0] i_pc, o_pc_target;
    logic [15:0] o_prog_addr, i_prog_data;
    logic [15:0] exp_q [$];
    logic [31:0] seed = 32'hCF3D;
    csr_op_e i_alu_op;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    csr_core #(.PC_W(13)) dut (.*);
    csr_prog_model prog (.i_clk(i_clk), .i_rd(o_prog_rd), .i_addr(o_prog_addr), .i_slow(slow),
                         .o_valid(i_prog_valid), .o_data(i_prog_data));
    ////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Counts: %0d compared, %0d mismatched", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic alu(input csr_op_e op, input logic [7:0] b);
        i_alu_go = 1'b1;
        i_alu_op = op;
        i_alu_b = b;
        tick();
        i_alu_go = 1'b0;
    endtask
    // Store data goes through the working register
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        alu(CSR_OP_PASS, v);
        i_mem_wr = 1'b1;
        i_mem_addr = a;
        tick();
        i_mem_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({8'h00, e});
        i_mem_rd = 1'b1;
        i_mem_addr = a;
        tick();
        i_mem_rd = 1'b0;
        tick();
    endtask
    // Pulse {soft reset, low-power qualifier, time-out, kick, halt}
    task automatic sysp(input logic [4:0] v);
        {i_soft_rst, i_soft_rst_wdt_lp, i_wdt_timeout, i_watchdog_kick_instr, i_halt} = v;
        tick();
        {i_soft_rst, i_soft_rst_wdt_lp, i_wdt_timeout, i_watchdog_kick_instr, i_halt} = 5'h00;
    endtask
    task automatic ac(input logic [7:0] f0, input csr_op_e op, input logic [7:0] a, b, w, f);
        wr(`CSR_ADDR_FLAGS, f0);
        alu(CSR_OP_PASS, a);
        alu(op, b);
        check({o_working_reg, o_flags}, {w, f});
        rd(`CSR_ADDR_WORK, w);
        rd(`CSR_ADDR_FLAGS, f);
    endtask
    ////////////////////////////////////////
    // Clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Monitor: each result takes the oldest note
    always @(negedge i_clk) begin
        if (o_mem_rvalid) check({8'h00, o_mem_rdata}, exp_q.pop_front());
        if (dummy_due) check({15'h0000, o_dummy_cycle}, 16'h0001);
        dummy_due = o_pc_load;
        if (o_pc_load) check({3'h0, o_pc_target}, exp_q.pop_front());
        if (o_prog_rd) check(o_prog_addr, exp_q.pop_front());
        if (o_tbl_low_valid) check({8'h00, o_tbl_low}, exp_q.pop_front());
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    // Main sequence
    initial begin
        {i_rst_n, i_soft_rst, i_soft_rst_wdt_lp, i_mem_rd, i_mem_wr, i_alu_go, i_tbl_rd} = 7'h00;
        {i_wdt_timeout, i_watchdog_kick_instr, i_halt, slow} = 4'h0;
        i_mem_addr = 8'h00;
        i_alu_b = 8'h00;
        i_alu_op = CSR_OP_PASS;
        i_pc = 13'h0000;
        tick(20);
        i_rst_n = 1'b1;
        tick();
        rd(`CSR_ADDR_BANK, 8'h00);
        rd(`CSR_ADDR_FLAGS, 8'h00);
        d = rnd();
        wr(`CSR_ADDR_PTR_A, 8'h85);
        wr(`CSR_ADDR_PORT_A, d);
        rd(8'h85, d);
        wr(`CSR_ADDR_PTR_A, `CSR_ADDR_PORT_B);
        rd(`CSR_ADDR_PORT_A, 8'h00);
        wr(`CSR_ADDR_PTR_A, `CSR_ADDR_PORT_A);
        wr(`CSR_ADDR_PORT_A, d);
        rd(`CSR_ADDR_PORT_A, 8'h00);
        wr(`CSR_ADDR_PTR_B, d);
        wr(`CSR_ADDR_PTR_A, `CSR_ADDR_PTR_B);
        rd(`CSR_ADDR_PORT_A, d);
        rd(8'h20, 8'h00);
        $display("indirect test done");
        for (int b = 0; b < 4; b++) begin
            dv[b] = rnd() | 8'h01;
            wr(`CSR_ADDR_BANK, 8'(b) | 8'hFC);
            rd(`CSR_ADDR_BANK, 8'(b));
            wr(`CSR_ADDR_PTR_B, 8'h90);
            wr(`CSR_ADDR_PORT_B, dv[b]);
            rd(`CSR_ADDR_PORT_B, (b == 3) ? 8'h00 : dv[b]);
            wr(`CSR_ADDR_PTR_B, 8'h10);
            rd(`CSR_ADDR_PORT_B, 8'h00);
        end
        wr(`CSR_ADDR_BANK, 8'h01);
        wr(`CSR_ADDR_PTR_B, 8'h90);
        rd(`CSR_ADDR_PORT_B, dv[1]);
        rd(8'h90, dv[0]);
        sysp(5'h18);
        rd(`CSR_ADDR_BANK, 8'h01);
        sysp(5'h10);
        rd(`CSR_ADDR_BANK, 8'h00);
        $display("bank test done");
        ac(8'h00, CSR_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h07);
        ac(8'h00, CSR_OP_ADD, 8'h7F, 8'h01, 8'h80, 8'h0A);
        ac(8'h01, CSR_OP_ADC, 8'h10, 8'h20, 8'h31, 8'h00);
        ac(8'h00, CSR_OP_SUB, 8'h05, 8'h03, 8'h02, 8'h03);
        ac(8'h00, CSR_OP_SUB, 8'h03, 8'h05, 8'hFE, 8'h00);
        ac(8'h01, CSR_OP_SBC, 8'h05, 8'h05, 8'h00, 8'h07);
        ac(8'h00, CSR_OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h04);
        ac(8'h08, CSR_OP_OR, 8'h00, 8'h00, 8'h00, 8'h0C);
        ac(8'h04, CSR_OP_XOR, 8'h5A, 8'h0F, 8'h55, 8'h00);
        ac(8'h00, CSR_OP_RLC, 8'h80, 8'h00, 8'h00, 8'h01);
        ac(8'h01, CSR_OP_RRC, 8'h02, 8'h00, 8'h81, 8'h00);
        ac(8'h06, CSR_OP_PASS, 8'h11, 8'h3C, 8'h3C, 8'h06);
        $display("flag test done");
        wr(`CSR_ADDR_FLAGS, 8'h00);
        sysp(5'h01);
        rd(`CSR_ADDR_FLAGS, 8'h10);
        sysp(5'h04);
        rd(`CSR_ADDR_FLAGS, 8'h30);
        sysp(5'h02);
        rd(`CSR_ADDR_FLAGS, 8'h00);
        sysp(5'h04);
        sysp(5'h01);
        rd(`CSR_ADDR_FLAGS, 8'h10);
        sysp(5'h05);
        wr(`CSR_ADDR_FLAGS, 8'h00);
        rd(`CSR_ADDR_FLAGS, 8'h30);
        i_rst_n = 1'b0;
        tick();
        i_rst_n = 1'b1;
        rd(`CSR_ADDR_FLAGS, 8'h00);
        $display("system flag test done");
        i_pc = {5'h0A, rnd()};
        d = rnd();
        exp_q.push_back({3'h0, i_pc[12:8], d});
        wr(`CSR_ADDR_PCL, d);
        tick(2);
        rd(`CSR_ADDR_PCL, i_pc[7:0]);
        for (int k = 0; k < 2; k++) begin
            slow = k[0];
            lo = rnd();
            hi = rnd();
            wr(`CSR_ADDR_TBL_LO, lo);
            wr(`CSR_ADDR_TBL_HI, hi);
            exp_q.push_back({hi, lo});
            exp_q.push_back({8'h00, lo ^ 8'hC3});
            i_tbl_rd = 1'b1;
            tick();
            i_tbl_rd = 1'b0;
            for (int n = 0; n < 20 && o_tbl_low_valid !== 1'b1; n++) tick();
            tick();
            rd(`CSR_ADDR_TBL_UP, hi ^ 8'hA5);
        end
        $display("jump and table test done");
        check(16'(exp_q.size()), 16'h0000);
        print_verdict();
    end
endmodule
